/* design/nidf_pkg.sv */
`default_nettype none
package nidf_pkg;
  // ==========================================================
  // Frame constants
  localparam logic [7:0] FRAME_TYPE = 8'h95;
  localparam logic [7:0] API_OPT_BASIC = 8'h00;
  localparam logic [15:0] ADDR16_UNKNOWN = 16'hfffe;
  localparam logic [7:0] TEXT_TERM = 8'h00;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  // Arbitrary neutral identifiers; replace per product
  localparam logic [15:0] PROFILE_ID = 16'h0a01;
  localparam logic [15:0] MAKER_ID = 16'h0b02;
  // ==========================================================
  // Byte offsets within the frame
  localparam logic [4:0] POS_TYPE = 5'h03;
  localparam logic [4:0] POS_SRC64 = 5'h04;
  localparam logic [4:0] POS_SRC64_END = 5'h0b;
  localparam logic [4:0] POS_SRC16 = 5'h0c;
  localparam logic [4:0] POS_OPTS = 5'h0e;
  localparam logic [4:0] POS_REM16 = 5'h0f;
  localparam logic [4:0] POS_REM64 = 5'h11;
  localparam logic [4:0] POS_HEAD_END = 5'h18;
  // ==========================================================
  // Sizes
  localparam int TEXT_MAX = 20;
  localparam logic [4:0] TEXT_MAX_LEN = 5'h14;
  localparam logic [2:0] TAIL_LAST = 3'h7;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 9;
  typedef enum logic [2:0] {ST_IDLE, ST_HEAD, ST_TEXT, ST_TAIL, ST_CSUM} nidf_state_type;
endpackage : nidf_pkg
`default_nettype wire

/* design/nidf_fifo.sv */
`default_nettype none
module nidf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Active low reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Reader takes data
  output logic [WIDTH-1:0] out_data // Read data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic wr_fire;
  logic rd_fire;

  assign in_ready = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign wr_fire = in_valid && in_ready;
  assign rd_fire = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (wr_fire) begin
        wr_ptr_q <= (wr_ptr_q == LAST_IDX) ? '0 : wr_ptr_q + 1'b1;
      end
      if (rd_fire) begin
        rd_ptr_q <= (rd_ptr_q == LAST_IDX) ? '0 : rd_ptr_q + 1'b1;
      end
      if (wr_fire && !rd_fire) begin
        count_q <= count_q + 1'b1;
      end else if (rd_fire && !wr_fire) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : nidf_fifo
`default_nettype wire

/* design/nidf_csum.sv */
`default_nettype none
module nidf_csum (
  input wire logic clk, // Clock
  input wire logic rst_n, // Active low reset
  input wire logic clear, // Start a new frame
  input wire logic add_en, // Add one byte
  input wire logic [7:0] add_byte, // Byte to add
  output logic [7:0] csum // Checksum of bytes so far
);
  logic [7:0] sum_q;

  // Modulo-256 sum; the checksum is the base minus it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= '0;
    end else if (clear) begin
      sum_q <= '0;
    end else if (add_en) begin
      sum_q <= sum_q + add_byte;
    end
  end

  assign csum = nidf_pkg::CSUM_BASE - sum_q;
endmodule : nidf_csum
`default_nettype wire

/* design/nidf_framer.sv */
`default_nettype none
// Summary of operation
// - Frame type byte carries 0x95.
// - Frame is sent only for a received identification while output option is 0.
// - Sender 64-bit address in bytes 4 to 11, most significant first.
// - Sender 16-bit address in bytes 12 and 13, most significant first.
// - Receive options byte 14: 0x01 acknowledged, 0x02 broadcast.
// - Remote 16-bit address in bytes 15 and 16, 0xFFFE when unknown.
// - Remote 64-bit address in bytes 17 to 24.
// - Identifier text from byte 25, ended by one 0x00 byte.
// - Device role byte: 0 coordinator, 1 router, 2 end device.
// - Trigger byte: 1 pushbutton, 2 network join, 3 power cycle.
// - Two-byte profile identifier then two-byte maker identifier.
module nidf_framer (
  input wire logic MCLK, // 100 MHz clock
  input wire logic ARST_N, // Asynchronous reset, active low
  input wire logic NID_VALID, // Identification message received
  output logic NID_READY, // Framer idle, takes a message
  output logic NID_DROPPED, // Pulse: message ignored, option not basic
  input wire logic [7:0] API_OUTPUT_OPTION, // Output option setting
  input wire logic [63:0] SRC_ADDR64, // Sender 64-bit address
  input wire logic [15:0] SRC_ADDR16, // Sender 16-bit address
  input wire logic RX_ACKED, // Packet was acknowledged
  input wire logic RX_BCAST, // Packet was a broadcast
  input wire logic [15:0] REM_ADDR16, // Remote 16-bit address
  input wire logic REM_ADDR16_KNOWN, // Remote 16-bit address is known
  input wire logic [63:0] REM_ADDR64, // Remote 64-bit address
  input wire logic [159:0] NODE_IDENTIFIER_TEXT, // Text, char 0 in bits 7:0
  input wire logic [4:0] NODE_IDENTIFIER_LEN, // Text length, at most 20
  input wire logic [15:0] PARENT_ADDR16, // Parent 16-bit address
  input wire logic PARENT_VALID, // A parent applies
  input wire logic [1:0] DEVICE_ROLE, // Remote role code
  input wire logic [1:0] TRIGGER_CAUSE, // Triggering event code
  output logic [7:0] HOST_DATA, // Frame byte to host
  output logic HOST_VALID, // Frame byte valid
  output logic HOST_LAST, // Checksum byte, end of frame
  input wire logic HOST_READY // Host takes byte
);
  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // Capture
  nidf_pkg::nidf_state_type state_q;
  logic [63:0] src64_q;
  logic [15:0] src16_q;
  logic [7:0] opts_q;
  logic [15:0] rem16_q;
  logic [63:0] rem64_q;
  logic [7:0] text_q [nidf_pkg::TEXT_MAX];
  logic [4:0] text_len_q;
  logic [15:0] parent_q;
  logic [7:0] role_q;
  logic [7:0] cause_q;
  logic [4:0] pos_q;
  logic [4:0] text_idx_q;
  logic [2:0] tail_idx_q;
  logic accept;
  logic start;
  logic wr_valid;
  logic wr_ready;
  logic wr_fire;
  logic [7:0] wr_byte;
  logic [7:0] text_byte;
  logic [7:0] head_byte;
  logic [7:0] tail_byte;
  logic [7:0] csum;

  assign accept = NID_VALID && NID_READY;
  assign start = accept && (API_OUTPUT_OPTION == nidf_pkg::API_OPT_BASIC);

  always_ff @(posedge MCLK) begin
    if (start) begin
      src64_q <= SRC_ADDR64;
      src16_q <= SRC_ADDR16;
      opts_q <= {6'h00, RX_BCAST, RX_ACKED};
      rem16_q <= REM_ADDR16_KNOWN ? REM_ADDR16 : nidf_pkg::ADDR16_UNKNOWN;
      rem64_q <= REM_ADDR64;
      parent_q <= PARENT_VALID ? PARENT_ADDR16 : nidf_pkg::ADDR16_UNKNOWN;
      role_q <= {6'h00, DEVICE_ROLE};
      cause_q <= {6'h00, TRIGGER_CAUSE};
      text_len_q <= (NODE_IDENTIFIER_LEN > nidf_pkg::TEXT_MAX_LEN) ? nidf_pkg::TEXT_MAX_LEN : NODE_IDENTIFIER_LEN;
      for (int i = 0; i < nidf_pkg::TEXT_MAX; i++) begin
        text_q[i] <= NODE_IDENTIFIER_TEXT[8*i +: 8];
      end
    end
  end

  // ==========================================================
  // Byte selection
  always_comb begin
    head_byte = nidf_pkg::FRAME_TYPE;
    if (pos_q >= nidf_pkg::POS_REM64) begin
      head_byte = rem64_q[8*(7 - (pos_q - nidf_pkg::POS_REM64)) +: 8];
    end else if (pos_q >= nidf_pkg::POS_REM16) begin
      head_byte = (pos_q == nidf_pkg::POS_REM16) ? rem16_q[15:8] : rem16_q[7:0];
    end else if (pos_q == nidf_pkg::POS_OPTS) begin
      head_byte = opts_q;
    end else if (pos_q >= nidf_pkg::POS_SRC16) begin
      head_byte = (pos_q == nidf_pkg::POS_SRC16) ? src16_q[15:8] : src16_q[7:0];
    end else if (pos_q >= nidf_pkg::POS_SRC64) begin
      head_byte = src64_q[8*(7 - (pos_q - nidf_pkg::POS_SRC64)) +: 8];
    end
  end

  // Stops at the length or at an embedded null, whichever comes first
  assign text_byte = (text_idx_q >= text_len_q) ? nidf_pkg::TEXT_TERM : text_q[text_idx_q];

  always_comb begin
    case (tail_idx_q)
      3'h0: tail_byte = parent_q[15:8];
      3'h1: tail_byte = parent_q[7:0];
      3'h2: tail_byte = role_q;
      3'h3: tail_byte = cause_q;
      3'h4: tail_byte = nidf_pkg::PROFILE_ID[15:8];
      3'h5: tail_byte = nidf_pkg::PROFILE_ID[7:0];
      3'h6: tail_byte = nidf_pkg::MAKER_ID[15:8];
      default: tail_byte = nidf_pkg::MAKER_ID[7:0];
    endcase
  end

  always_comb begin
    case (state_q)
      nidf_pkg::ST_HEAD: wr_byte = head_byte;
      nidf_pkg::ST_TEXT: wr_byte = text_byte;
      nidf_pkg::ST_TAIL: wr_byte = tail_byte;
      nidf_pkg::ST_CSUM: wr_byte = csum;
      default: wr_byte = 8'h00;
    endcase
  end

  assign wr_valid = (state_q != nidf_pkg::ST_IDLE);
  assign wr_fire = wr_valid && wr_ready;

  // ==========================================================
  // Sequencer
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= nidf_pkg::ST_IDLE;
      pos_q <= nidf_pkg::POS_TYPE;
      text_idx_q <= '0;
      tail_idx_q <= '0;
    end else begin
      case (state_q)
        nidf_pkg::ST_IDLE: begin
          pos_q <= nidf_pkg::POS_TYPE;
          text_idx_q <= '0;
          tail_idx_q <= '0;
          if (start) begin
            state_q <= nidf_pkg::ST_HEAD;
          end
        end
        nidf_pkg::ST_HEAD: begin
          if (wr_fire) begin
            pos_q <= pos_q + 5'h01;
            if (pos_q == nidf_pkg::POS_HEAD_END) begin
              state_q <= nidf_pkg::ST_TEXT;
            end
          end
        end
        nidf_pkg::ST_TEXT: begin
          if (wr_fire) begin
            text_idx_q <= text_idx_q + 5'h01;
            if (text_byte == nidf_pkg::TEXT_TERM) begin
              state_q <= nidf_pkg::ST_TAIL;
            end
          end
        end
        nidf_pkg::ST_TAIL: begin
          if (wr_fire) begin
            tail_idx_q <= tail_idx_q + 3'h1;
            if (tail_idx_q == nidf_pkg::TAIL_LAST) begin
              state_q <= nidf_pkg::ST_CSUM;
            end
          end
        end
        nidf_pkg::ST_CSUM: begin
          if (wr_fire) begin
            state_q <= nidf_pkg::ST_IDLE;
          end
        end
        default: state_q <= nidf_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      NID_READY <= 1'b0;
      NID_DROPPED <= 1'b0;
    end else begin
      NID_DROPPED <= accept && !start;
      if (start) begin
        NID_READY <= 1'b0;
      end else if (state_q == nidf_pkg::ST_IDLE || (state_q == nidf_pkg::ST_CSUM && wr_fire)) begin
        NID_READY <= 1'b1;
      end
    end
  end

  nidf_csum u_csum (
    .clk(MCLK),
    .rst_n(rst_n),
    .clear(start),
    .add_en(wr_fire && state_q != nidf_pkg::ST_CSUM),
    .add_byte(wr_byte),
    .csum(csum)
  );

  // ==========================================================
  // Output buffer and host stage
  logic fifo_valid;
  logic fifo_ready;
  logic [nidf_pkg::FIFO_WIDTH-1:0] fifo_data;

  nidf_fifo #(
    .WIDTH(nidf_pkg::FIFO_WIDTH),
    .DEPTH(nidf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({state_q == nidf_pkg::ST_CSUM, wr_byte}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  assign fifo_ready = !HOST_VALID || HOST_READY;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_VALID <= 1'b0;
      HOST_DATA <= 8'h00;
      HOST_LAST <= 1'b0;
    end else if (fifo_ready) begin
      HOST_VALID <= fifo_valid;
      if (fifo_valid) begin
        HOST_DATA <= fifo_data[7:0];
        HOST_LAST <= fifo_data[8];
      end
    end
  end

  // ==========================================================
  // Checks
  logic [7:0] chk_sum_q;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      chk_sum_q <= '0;
    end else if (start) begin
      chk_sum_q <= '0;
    end else if (wr_fire) begin
      chk_sum_q <= chk_sum_q + wr_byte;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  type_byte_a: assert property (wr_fire && state_q == nidf_pkg::ST_HEAD && pos_q == nidf_pkg::POS_TYPE
    |-> wr_byte == 8'h95) else $error("frame type byte wrong");
  option_gate_a: assert property (accept && API_OUTPUT_OPTION != 8'h00
    |=> state_q == nidf_pkg::ST_IDLE && NID_DROPPED) else $error("frame sent with option not basic");
  start_frame_a: assert property (start |=> state_q == nidf_pkg::ST_HEAD && pos_q == 5'h03 && !NID_READY)
    else $error("accepted message did not start a frame");
  src64_msb_a: assert property (wr_fire && state_q == nidf_pkg::ST_HEAD && pos_q == 5'h04
    |-> wr_byte == src64_q[63:56]) else $error("sender address order wrong");
  src16_lsb_a: assert property (wr_fire && state_q == nidf_pkg::ST_HEAD && pos_q == 5'h0d
    |-> wr_byte == src16_q[7:0]) else $error("sender short address wrong");
  opts_byte_a: assert property (start && RX_BCAST && !RX_ACKED
    |=> opts_q == 8'h02) else $error("receive options wrong");
  rem16_unknown_a: assert property (start && !REM_ADDR16_KNOWN |=> rem16_q == 16'hfffe)
    else $error("unknown remote address not substituted");
  rem64_lsb_a: assert property (wr_fire && state_q == nidf_pkg::ST_HEAD && pos_q == 5'h18
    |-> wr_byte == rem64_q[7:0] ##1 state_q == nidf_pkg::ST_TEXT) else $error("remote address end wrong");
  text_term_a: assert property (wr_fire && state_q == nidf_pkg::ST_TEXT && wr_byte == 8'h00
    |=> state_q == nidf_pkg::ST_TAIL && tail_idx_q == 3'h0) else $error("text terminator handling wrong");
  text_bound_a: assert property (state_q == nidf_pkg::ST_TEXT |-> text_idx_q <= text_len_q)
    else $error("text ran past its length");
  role_cause_a: assert property (wr_fire && state_q == nidf_pkg::ST_TAIL && tail_idx_q == 3'h2
    |-> wr_byte == role_q ##1 wr_byte == cause_q) else $error("role or trigger byte wrong");
  ident_a: assert property (wr_fire && state_q == nidf_pkg::ST_TAIL && tail_idx_q == 3'h4
    |-> wr_byte == nidf_pkg::PROFILE_ID[15:8]) else $error("profile identifier wrong");
  parent_a: assert property (start && !PARENT_VALID |=> parent_q == 16'hfffe)
    else $error("missing parent not substituted");
  csum_a: assert property (wr_fire && state_q == nidf_pkg::ST_CSUM |-> 8'(chk_sum_q + wr_byte) == 8'hff)
    else $error("checksum wrong");

  frame_done_c: cover property (wr_fire && state_q == nidf_pkg::ST_CSUM);
  drop_c: cover property (NID_DROPPED);
  fifo_full_c: cover property (wr_valid && !wr_ready);
  long_text_c: cover property (state_q == nidf_pkg::ST_TEXT && text_idx_q == 5'h14);
endmodule : nidf_framer
`default_nettype wire

/* dv/nidf_host_model.sv */
`default_nettype none
module nidf_host_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Active low reset
  input wire logic [7:0] host_data, // Frame byte
  input wire logic host_valid, // Byte valid
  input wire logic host_last, // Checksum byte
  input wire logic [1:0] stall_mode, // 0 ready, 1 random, 2 mostly stalled
  output logic host_ready // Byte accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cur_q[$];
  logic [7:0] done_q[$];
  logic [7:0] sum_q = 8'h00;
  int frames = 0;
  int csum_bad = 0;
  // ==========================================================
  // Ready pattern, changed away from the sampling edge
  always @(negedge clk) begin
    case (stall_mode)
      2'h1: host_ready <= 1'($urandom_range(0, 1));
      2'h2: host_ready <= ($urandom_range(0, 3) == 0);
      default: host_ready <= 1'b1;
    endcase
  end
  // ==========================================================
  // Collect bytes, close the frame on the last one
  always @(posedge clk) begin
    if (rst_n && host_valid && host_ready) begin
      cur_q.push_back(host_data);
      sum_q = sum_q + host_data;
      if (host_last) begin
        if (sum_q != 8'hff) csum_bad++;
        done_q = cur_q;
        cur_q = {};
        sum_q = 8'h00;
        frames++;
      end
    end
  end
endmodule : nidf_host_model
`default_nettype wire

/* dv/nidf_framer_tb_top.sv */
`default_nettype none
module nidf_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic nid_valid = 1'b0;
  logic [7:0] api_opt = 8'h00;
  logic [63:0] src64 = '0;
  logic [63:0] rem64 = '0;
  logic [15:0] src16 = '0;
  logic [15:0] rem16 = '0;
  logic [15:0] parent16 = '0;
  logic acked = 1'b0;
  logic bcast = 1'b0;
  logic rem_known = 1'b0;
  logic parent_ok = 1'b0;
  logic [159:0] text = '0;
  logic [4:0] text_len = '0;
  logic [1:0] role = '0;
  logic [1:0] cause = '0;
  logic [1:0] stall_mode = '0;
  logic nid_ready;
  logic nid_dropped;
  logic [7:0] host_data;
  logic host_valid;
  logic host_last;
  logic host_ready;
  logic [7:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  always #5 mclk = ~mclk;
  nidf_framer u_dut (.MCLK(mclk), .ARST_N(arst_n), .NID_VALID(nid_valid), .NID_READY(nid_ready),
    .NID_DROPPED(nid_dropped), .API_OUTPUT_OPTION(api_opt), .SRC_ADDR64(src64), .SRC_ADDR16(src16),
    .RX_ACKED(acked), .RX_BCAST(bcast), .REM_ADDR16(rem16), .REM_ADDR16_KNOWN(rem_known),
    .REM_ADDR64(rem64), .NODE_IDENTIFIER_TEXT(text), .NODE_IDENTIFIER_LEN(text_len),
    .PARENT_ADDR16(parent16), .PARENT_VALID(parent_ok), .DEVICE_ROLE(role), .TRIGGER_CAUSE(cause),
    .HOST_DATA(host_data), .HOST_VALID(host_valid), .HOST_LAST(host_last), .HOST_READY(host_ready));
  nidf_host_model u_host (.clk(mclk), .rst_n(arst_n), .host_data(host_data), .host_valid(host_valid),
    .host_last(host_last), .stall_mode(stall_mode), .host_ready(host_ready));
  // ==========================================================
  // Checking and expectation helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic void push_be(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[8*i+:8]);
  endfunction : push_be
  function automatic void build_exp();
    logic [7:0] s;
    int k;
    exp_q = {8'h95};
    push_be(src64, 8);
    push_be(src16, 2);
    exp_q.push_back({6'h00, bcast, acked});
    push_be(rem_known ? rem16 : 16'hfffe, 2);
    push_be(rem64, 8);
    k = 0;
    while (k < 20 && k < text_len && text[8*k+:8] != 8'h00) begin
      exp_q.push_back(text[8*k+:8]);
      k++;
    end
    exp_q.push_back(8'h00);
    push_be(parent_ok ? parent16 : 16'hfffe, 2);
    exp_q.push_back({6'h00, role});
    exp_q.push_back({6'h00, cause});
    push_be(nidf_pkg::PROFILE_ID, 2);
    push_be(nidf_pkg::MAKER_ID, 2);
    s = 8'h00;
    foreach (exp_q[i]) s = s + exp_q[i];
    exp_q.push_back(8'hff - s);
  endfunction : build_exp
  // ==========================================================
  // Message and frame sequences
  task automatic send_msg();
    nid_valid = 1'b1;
    while (nid_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    nid_valid = 1'b0;
  endtask : send_msg
  task automatic rand_fields(input int i);
    src64 = {$urandom, $urandom};
    rem64 = {$urandom, $urandom};
    src16 = 16'($urandom);
    rem16 = 16'($urandom);
    parent16 = 16'($urandom);
    {acked, bcast, rem_known, parent_ok} = 4'($urandom);
    for (int c = 0; c < 20; c++) text[8*c+:8] = 8'($urandom_range(1, 255));
    text_len = 5'($urandom_range(0, 20));
    role = 2'(i % 3);
    cause = 2'(1 + i % 3);
    stall_mode = 2'(i % 3);
  endtask : rand_fields
  task automatic run_frame();
    int f0;
    int n;
    build_exp();
    f0 = u_host.frames;
    send_msg();
    n = 0;
    while (u_host.frames == f0 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    check("frame_done", n < 600, 1'b1);
    check("frame_len", u_host.done_q.size(), exp_q.size());
    foreach (exp_q[i]) check("frame_byte", u_host.done_q[i], exp_q[i]);
  endtask : run_frame
  task automatic run_drop();
    int f0;
    int hits;
    f0 = u_host.frames;
    api_opt = 8'($urandom_range(1, 255));
    send_msg();
    hits = int'(nid_dropped === 1'b1);
    @(negedge mclk);
    hits += int'(nid_dropped === 1'b1);
    check("drop_pulse", hits, 1);
    check("ready_after_drop", nid_ready, 1'b1);
    send_msg();
    repeat (30) @(negedge mclk);
    check("frames_after_drop", u_host.frames, f0);
    api_opt = 8'h00;
  endtask : run_drop
  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    void'($urandom(79));
    repeat (6) @(negedge mclk);
    check("reset_valid", host_valid, 1'b0);
    check("reset_ready", nid_ready, 1'b0);
    arst_n = 1'b1;
    @(negedge mclk);
    src64 = 64'h1122334455667788;
    src16 = 16'h7d84;
    {acked, bcast, rem_known, parent_ok} = 4'b0110;
    rem16 = 16'h7d84;
    rem64 = src64;
    text = 160'h20;
    text_len = 5'h01;
    role = 2'h1;
    cause = 2'h1;
    run_frame();
    rand_fields(1);
    text_len = 5'h14;
    run_frame();
    rand_fields(2);
    text_len = 5'h05;
    text[23:16] = 8'h00;
    run_frame();
    rand_fields(3);
    text_len = 5'h00;
    run_frame();
    // Length above the limit is clamped to 20 characters
    rand_fields(4);
    text_len = 5'h1f;
    run_frame();
    run_drop();
    for (int i = 0; i < 12; i++) begin
      rand_fields(i);
      run_frame();
    end
    check("host_csum_errors", u_host.csum_bad, 0);
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
endmodule : nidf_framer_tb_top
`default_nettype wire
